// *** ptci_top.sv ***
// Pulse-train channel: APB register file, parameter staging and pulse sequencer.
//
// Overview of operation
// - Period, delay, duty staged via staging word.
// - Undefined selector codes invalid; value not applied.
// - Invalid code: load error or value error.
// - Selector zero ignores staging word.
// - Selector one loads period in microseconds.
// - Two loads on-delay; four loads duty.
// - Policy bit four: single or permanent.
// - Enable bit zero starts and stops sequence.
// - Plain input: rising enable starts, low stops.
// - Gate role: enable permits, filtered pin starts.
// - On-delay precedes first pulse of train.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "ptci_defs.svh"
module ptci_top #(
  parameter int TICK_CYCLES = `PTCI_TICK_CYCLES,
  parameter int FILTER_CYCLES = `PTCI_FILTER_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Hardware gate input pin.
  input wire logic gate_pin,
  // Pulse output and status.
  output logic pulse_out,
  output logic sequence_active,
  output logic irq
);
  logic [31:0] pulse_count;
  logic [31:0] staged_value;
  logic [4:0] staging_selector;
  logic software_sequence_enable;
  logic input_pin_role;
  logic [1:0] duty_format;
  logic [2:0] status;
  logic [2:0] mask;
  logic [31:0] period_us;
  logic [31:0] on_delay_us;
  logic [31:0] duty;
  logic [31:0] pulses_left;
  logic [31:0] pulses_done;
  logic [31:0] us_count;
  ptci_pkg::ptci_state_t state;
  ptci_pkg::ptci_state_t next_state;
  logic [7:0] index;
  logic mapped;
  logic access;
  logic wr;
  logic sel_written;
  logic enable_prev;
  logic gate_level;
  logic gate_prev;
  logic tick;
  logic start_req;
  logic stop_req;
  logic apply_now;
  logic code_valid;
  logic [3:0] code;
  logic policy;
  logic [15:0] scale;
  logic [47:0] high_limit;
  logic [47:0] phase_scaled;
  logic set_load_err;
  logic set_value_err;
  logic set_done;
  logic [2:0] status_set;
  logic [31:0] read_word;

  assign index = paddr[9:2];
  assign access = psel && penable && pready;
  assign wr = access && pwrite && mapped;
  assign code = staging_selector[`PTCI_SEL_CODE_MSB:0];
  assign policy = staging_selector[`PTCI_SEL_POLICY_BIT];

  always_comb begin
    case (index)
      `PTCI_IDX_PULSE_COUNT, `PTCI_IDX_STAGED_VALUE, `PTCI_IDX_SELECTOR,
      `PTCI_IDX_ENABLE, `PTCI_IDX_CONFIG, `PTCI_IDX_STATUS,
      `PTCI_IDX_MASK, `PTCI_IDX_PROGRESS: mapped = (paddr[11:10] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  // Exactly one wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      // Refused and write cycles return zero, so no register leaks out on an error.
      prdata <= (pwrite || !mapped) ? 32'h00000000 : read_word;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    read_word = 32'h00000000;
    case (index)
      `PTCI_IDX_PULSE_COUNT: read_word = pulse_count;
      `PTCI_IDX_STAGED_VALUE: read_word = staged_value;
      `PTCI_IDX_SELECTOR: read_word = {27'h0000000, staging_selector};
      `PTCI_IDX_ENABLE: read_word = {31'h00000000, software_sequence_enable};
      `PTCI_IDX_CONFIG: read_word = {26'h0000000, duty_format, 3'h0, input_pin_role};
      `PTCI_IDX_STATUS: read_word = {23'h000000, sequence_active, 5'h00, status};
      `PTCI_IDX_MASK: read_word = {29'h00000000, mask};
      `PTCI_IDX_PROGRESS: read_word = pulses_done;
      default: read_word = 32'h00000000;
    endcase
  end

  // Software-written registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_count <= 32'h00000000;
      staged_value <= 32'h00000000;
      staging_selector <= 5'h00;
      software_sequence_enable <= 1'b0;
      input_pin_role <= 1'b0;
      duty_format <= `PTCI_RST_FMT;
      mask <= 3'h0;
    end else if (wr) begin
      case (index)
        `PTCI_IDX_PULSE_COUNT: pulse_count <= pwdata;
        `PTCI_IDX_STAGED_VALUE: staged_value <= pwdata;
        `PTCI_IDX_SELECTOR: staging_selector <= pwdata[4:0];
        `PTCI_IDX_ENABLE: software_sequence_enable <= pwdata[`PTCI_ENABLE_BIT];
        `PTCI_IDX_CONFIG: begin
          input_pin_role <= pwdata[`PTCI_CFG_ROLE_BIT];
          duty_format <= pwdata[`PTCI_CFG_FMT_MSB:`PTCI_CFG_FMT_LSB];
        end
        `PTCI_IDX_MASK: mask <= pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // A single-update load fires once, the cycle after the selector is written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_written <= 1'b0;
    end else begin
      sel_written <= wr && (index == `PTCI_IDX_SELECTOR);
    end
  end

  always_comb begin
    case (code)
      `PTCI_CODE_PERIOD, `PTCI_CODE_ON_DELAY, `PTCI_CODE_DUTY: code_valid = 1'b1;
      default: code_valid = 1'b0;
    endcase
  end

  // Permanent policy tracks the staging word every cycle.
  assign apply_now = policy ? 1'b1 : sel_written;
  assign set_load_err = apply_now && !policy && !code_valid &&
    (code != `PTCI_CODE_IDLE);
  assign set_value_err = apply_now && policy && !code_valid &&
    (code != `PTCI_CODE_IDLE);

  // Working parameters; an idle or invalid code leaves them untouched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_us <= `PTCI_RST_PERIOD;
      on_delay_us <= `PTCI_RST_ON_DELAY;
      duty <= `PTCI_RST_DUTY;
    end else if (apply_now && code_valid) begin
      case (code)
        `PTCI_CODE_PERIOD: period_us <= staged_value;
        `PTCI_CODE_ON_DELAY: on_delay_us <= staged_value;
        `PTCI_CODE_DUTY: duty <= staged_value;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (duty_format)
      2'h0: scale = `PTCI_SCALE_ANALOG;
      2'h1: scale = `PTCI_SCALE_PCT;
      2'h2: scale = `PTCI_SCALE_PERMILLE;
      default: scale = `PTCI_SCALE_PER10K;
    endcase
  end

  ptci_filter #(
    .CYCLES(FILTER_CYCLES)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pin(gate_pin),
    .level(gate_level)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_prev <= 1'b0;
      gate_prev <= 1'b0;
    end else begin
      enable_prev <= software_sequence_enable;
      gate_prev <= gate_level;
    end
  end

  // Plain role starts on the enable edge; gate role starts on the pin edge.
  assign start_req = input_pin_role ?
    (software_sequence_enable && gate_level && !gate_prev) :
    (software_sequence_enable && !enable_prev);
  assign stop_req = !software_sequence_enable;

  ptci_tick #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .restart(start_req && (state == ptci_pkg::PTCI_IDLE)),
    .tick(tick)
  );

  // Duty clamps at full scale because the limit never exceeds period times scale.
  assign high_limit = (duty > {16'h0000, scale}) ?
    (48'(period_us) * 48'(scale)) : (48'(period_us) * 48'(duty[15:0]));
  assign phase_scaled = 48'(us_count) * 48'(scale);

  always_comb begin
    next_state = state;
    set_done = 1'b0;
    case (state)
      ptci_pkg::PTCI_IDLE: begin
        if (start_req) begin
          next_state = ptci_pkg::PTCI_DELAY;
        end
      end
      ptci_pkg::PTCI_DELAY: begin
        if (stop_req) begin
          next_state = ptci_pkg::PTCI_IDLE;
        end else if (tick && (us_count >= on_delay_us)) begin
          next_state = (pulse_count == 32'h00000000) ?
            ptci_pkg::PTCI_IDLE : ptci_pkg::PTCI_TRAIN;
          set_done = (pulse_count == 32'h00000000);
        end
      end
      ptci_pkg::PTCI_TRAIN: begin
        if (stop_req) begin
          next_state = ptci_pkg::PTCI_IDLE;
        end else if (tick && (us_count + 32'h00000001 >= period_us) &&
            (pulses_left == 32'h00000001)) begin
          next_state = ptci_pkg::PTCI_IDLE;
          set_done = 1'b1;
        end
      end
      default: next_state = ptci_pkg::PTCI_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ptci_pkg::PTCI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Time and pulse counters of the running sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_count <= 32'h00000000;
      pulses_left <= 32'h00000000;
      pulses_done <= 32'h00000000;
    end else if (state == ptci_pkg::PTCI_IDLE) begin
      us_count <= 32'h00000000;
      if (start_req) begin
        pulses_done <= 32'h00000000;
      end
    end else if (state == ptci_pkg::PTCI_DELAY) begin
      if (tick && (us_count >= on_delay_us)) begin
        us_count <= 32'h00000000;
        pulses_left <= pulse_count;
      end else if (tick) begin
        us_count <= us_count + 32'h00000001;
      end
    end else if (tick) begin
      if (us_count + 32'h00000001 >= period_us) begin
        us_count <= 32'h00000000;
        pulses_left <= pulses_left - 32'h00000001;
        pulses_done <= pulses_done + 32'h00000001;
      end else begin
        us_count <= us_count + 32'h00000001;
      end
    end
  end

  // Output is high for the duty share of each period and low outside the train.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_out <= 1'b0;
      sequence_active <= 1'b0;
    end else begin
      pulse_out <= (next_state == ptci_pkg::PTCI_TRAIN) &&
        (state == ptci_pkg::PTCI_TRAIN) && (phase_scaled < high_limit);
      sequence_active <= (next_state != ptci_pkg::PTCI_IDLE);
    end
  end

  // Sticky status, write one to clear; a new event wins over a clear.
  assign status_set = {set_done, set_value_err, set_load_err};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 3'h0;
    end else if (wr && (index == `PTCI_IDX_STATUS)) begin
      status <= (status & ~pwdata[2:0]) | status_set;
    end else begin
      status <= status | status_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

endmodule // ptci_top

// *** ptci_defs.svh ***
// Register offsets, field positions, reset values and timing counts of the pulse-train block.
`ifndef PTCI_DEFS_SVH
`define PTCI_DEFS_SVH

// Printed register indices; the byte address is four times the index.
`define PTCI_IDX_PULSE_COUNT 8'h00
`define PTCI_IDX_STAGED_VALUE 8'h04
`define PTCI_IDX_SELECTOR 8'h08
`define PTCI_IDX_ENABLE 8'h09
`define PTCI_IDX_CONFIG 8'h10
`define PTCI_IDX_STATUS 8'h11
`define PTCI_IDX_MASK 8'h12
`define PTCI_IDX_PROGRESS 8'h13

// Selector field positions and codes, and the enable bit.
`define PTCI_SEL_CODE_MSB 3
`define PTCI_SEL_POLICY_BIT 4
`define PTCI_CODE_IDLE 4'h0
`define PTCI_CODE_PERIOD 4'h1
`define PTCI_CODE_ON_DELAY 4'h2
`define PTCI_CODE_DUTY 4'h4
`define PTCI_ENABLE_BIT 0

// Configuration fields.
`define PTCI_CFG_ROLE_BIT 0
`define PTCI_CFG_FMT_LSB 4
`define PTCI_CFG_FMT_MSB 5

// Status and mask bits.
`define PTCI_ST_LOAD_ERR 0
`define PTCI_ST_VALUE_ERR 1
`define PTCI_ST_DONE 2
`define PTCI_ST_BUSY 8

// Duty-cycle full-scale values for each output format.
`define PTCI_SCALE_ANALOG 16'h6C00
`define PTCI_SCALE_PCT 16'h0064
`define PTCI_SCALE_PERMILLE 16'h03E8
`define PTCI_SCALE_PER10K 16'h2710

// Reset values of the working parameters and the duty format.
`define PTCI_RST_PERIOD 32'h001E8480
`define PTCI_RST_ON_DELAY 32'h00000000
`define PTCI_RST_DUTY 32'h00000032
`define PTCI_RST_FMT 2'h1

// Timing: clock period, one-microsecond time base and input filter time.
`define PTCI_CLK_NS 5
`define PTCI_TICK_NS 1000
`define PTCI_TICK_CYCLES (`PTCI_TICK_NS / `PTCI_CLK_NS)
`define PTCI_FILTER_NS 100000
`define PTCI_FILTER_CYCLES (`PTCI_FILTER_NS / `PTCI_CLK_NS)

`endif

// *** ptci_pkg.sv ***
// Types shared by the pulse-train control block.
package ptci_pkg;

  typedef enum logic [1:0] {
    PTCI_IDLE,
    PTCI_DELAY,
    PTCI_TRAIN
  } ptci_state_t;

endpackage

// *** ptci_tick.sv ***
// One-cycle enable pulse every DIV clocks, restartable to align the time base.
`timescale 1ns/1ps
module ptci_tick #(
  parameter int DIV = 200
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control and output.
  input wire logic restart,
  output logic tick
);
  logic [15:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (restart) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (count == 16'(DIV - 1)) begin
      count <= 16'h0000;
      tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // ptci_tick

// *** ptci_filter.sv ***
// Two-flop synchroniser and stability filter for the external input pin.
`timescale 1ns/1ps
module ptci_filter #(
  parameter int CYCLES = 20000
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pin and filtered level.
  input wire logic pin,
  output logic level
);
  logic meta;
  logic sync;
  logic [23:0] stable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
    end
  end

  // The level only follows the pin after it has held for the full filter time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable <= 24'h000000;
      level <= 1'b0;
    end else if (sync == level) begin
      stable <= 24'h000000;
    end else if (stable >= 24'(CYCLES - 1)) begin
      stable <= 24'h000000;
      level <= sync;
    end else begin
      stable <= stable + 24'h000001;
    end
  end
endmodule // ptci_filter

// *** ptci_checker.sv ***
// Port assertions for the pulse-train channel.
`timescale 1ns/1ps
module ptci_checker (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and outputs.
  input wire logic gate_pin,
  input wire logic pulse_out,
  input wire logic sequence_active,
  input wire logic irq
);
  logic mapped;
  assign mapped = paddr[11:10] == 2'h0
    && (paddr[9:2] inside {8'h00, 8'h04, 8'h08, 8'h09, [8'h10:8'h13]});
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not in second access cycle");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access phase");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_on_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_data_zero: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_selector_upper_zero: assert property (pready && !pwrite && paddr == 12'h020 |-> prdata[31:5] == 27'h0)
    else $error("selector upper bits not zero");
  a_stop_on_clear: assert property (pready && pwrite && paddr == 12'h024 && !pwdata[0] |=> ##[0:1] !sequence_active)
    else $error("sequence kept running after enable cleared");
  a_delay_output_low: assert property ($rose(sequence_active) |-> !pulse_out)
    else $error("pulse at sequence start");
  a_end_output_low: assert property ($fell(sequence_active) |=> !pulse_out && !sequence_active)
    else $error("output not low after sequence");
endmodule // ptci_checker

bind ptci_top ptci_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .gate_pin(gate_pin), .pulse_out(pulse_out),
  .sequence_active(sequence_active), .irq(irq));

// *** ptci_pin_model.sv ***
// Pin-side model: chattering gate source and pulse meter on the output.
`timescale 1ns/1ps
module ptci_pin_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bench controls and gate pin.
  input wire logic gate_req,
  input wire logic clear,
  output logic gate_pin,
  // Output and measures.
  input wire logic pulse_out,
  output logic [31:0] pulses,
  output logic [31:0] high_len
);
  logic [1:0] bounce;
  logic [31:0] run;
  // A contact rings for a few cycles, so the filter must reject it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_pin <= 1'b0;
      bounce <= 2'h0;
    end else if (bounce != 2'h0) begin
      bounce <= bounce - 2'h1;
      gate_pin <= (bounce == 2'h1) ? gate_req : !gate_pin;
    end else if (gate_pin != gate_req) begin
      bounce <= 2'h3;
      gate_pin <= gate_req;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 32'h0;
      pulses <= 32'h0;
      high_len <= 32'h0;
    end else begin
      run <= pulse_out ? run + 32'h1 : 32'h0;
      if (clear) pulses <= 32'h0;
      else if (pulse_out && run == 32'h0) pulses <= pulses + 32'h1;
      if (!pulse_out && run != 32'h0) high_len <= run;
    end
  end
endmodule // ptci_pin_model

// *** pulse_train_control_interface_tb.sv ***
// Self-checking bench for the pulse-train channel.
`timescale 1ns/1ps
`include "ptci_defs.svh"
module pulse_train_control_interface_tb;
  localparam int TK = 4;
  localparam logic [11:0] A_CNT = 12'(4 * `PTCI_IDX_PULSE_COUNT);
  localparam logic [11:0] A_SV = 12'(4 * `PTCI_IDX_STAGED_VALUE);
  localparam logic [11:0] A_SEL = 12'(4 * `PTCI_IDX_SELECTOR);
  localparam logic [11:0] A_EN = 12'(4 * `PTCI_IDX_ENABLE);
  localparam logic [11:0] A_CFG = 12'(4 * `PTCI_IDX_CONFIG);
  localparam logic [11:0] A_ST = 12'(4 * `PTCI_IDX_STATUS);
  localparam logic [11:0] A_MSK = 12'(4 * `PTCI_IDX_MASK);
  localparam logic [11:0] A_PRG = 12'(4 * `PTCI_IDX_PROGRESS);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic gate_req = 1'b0;
  logic clear = 1'b1;
  logic [31:0] rs = 32'h68F6;
  logic [31:0] prdata, pulses, high_len;
  logic pready, pslverr, gate_pin, pulse_out, sequence_active, irq;
  logic [32:0] q[$];
  int num_errors = 0;
  int check_count = 0;
  always #2.5 pclk = ~pclk;
  ptci_top #(.TICK_CYCLES(TK), .FILTER_CYCLES(3)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate_pin(gate_pin),
    .pulse_out(pulse_out), .sequence_active(sequence_active), .irq(irq));
  ptci_pin_model u_pin (.pclk(pclk), .presetn(presetn), .gate_req(gate_req), .clear(clear),
    .gate_pin(gate_pin), .pulse_out(pulse_out), .pulses(pulses), .high_len(high_len));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Notes pair with answers in order, since only one transfer is ever open.
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) cmp("bus note", 33'h0, 33'h1FFFFFFFF);
      else cmp("bus answer", q.pop_front(), {pslverr, prdata});
    end
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int n;
    q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b0, a, 32'h0, {1'b0, d});
  endtask
  task automatic wait_act(input logic v, input int lim);
    int n;
    n = 0;
    while (sequence_active !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      summarize();
    end
  endtask
  initial begin
    logic [31:0] n;
    int d;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    clear <= 1'b0;
    @(posedge pclk);
    rd(A_CFG, 32'h10);
    rd(A_ST, 32'h0);
    xfer(1'b0, 12'h080, 32'h0, {1'b1, 32'h0});
    wr(A_CNT, 32'hFFFFFFFF);
    rd(A_CNT, 32'hFFFFFFFF);
    xfer(1'b0, 12'h400, 32'h0, {1'b1, 32'h0});
    rs = xs(rs);
    wr(A_SV, rs);
    wr(A_SEL, 32'h0);
    rd(A_ST, 32'h0);
    wr(A_SEL, 32'h3);
    rd(A_ST, 32'h1);
    wr(A_SEL, 32'h1B);
    rd(A_ST, 32'h3);
    rd(A_SEL, 32'h1B);
    cmp("masked irq", 33'h0, {32'h0, irq});
    wr(A_SEL, 32'h10);
    wr(A_ST, 32'h3);
    rd(A_ST, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(A_SV, i == 0 ? 32'h8 : (i == 1 ? 32'h2 : 32'h19));
      wr(A_SEL, 32'(1 << i));
    end
    rd(A_ST, 32'h0);
    n = 32'h1 + (rs % 32'h3);
    wr(A_CNT, n);
    wr(A_MSK, 32'h4);
    wr(A_EN, 32'h1);
    wait_act(1'b1, 20);
    d = 0;
    while (pulse_out !== 1'b1 && d < 100) begin
      @(posedge pclk);
      d++;
    end
    cmp("on delay", 33'h1, {32'h0, d >= 2 * TK && d <= 3 * TK + 2});
    wait_act(1'b0, 2000);
    cmp("pulses", {1'b0, n}, {1'b0, pulses});
    cmp("high cycles", {1'b0, 32'(2 * TK)}, {1'b0, high_len});
    rd(A_PRG, n);
    rd(A_ST, 32'h4);
    cmp("done irq", 33'h1, {32'h0, irq});
    wr(A_ST, 32'h4);
    repeat (2) @(posedge pclk);
    cmp("cleared irq", 33'h0, {32'h0, irq});
    wr(A_EN, 32'h0);
    wr(A_CNT, 32'h64);
    wr(A_EN, 32'h1);
    repeat (100) @(posedge pclk);
    cmp("running", 33'h1, {32'h0, sequence_active});
    wr(A_EN, 32'h0);
    @(posedge pclk);
    cmp("stopped", 33'h0, {32'h0, sequence_active});
    rd(A_ST, 32'h0);
    wr(A_CFG, 32'h31);
    wr(A_SEL, 32'h14);
    wr(A_SV, 32'h9C4);
    wr(A_CNT, 32'h2);
    wr(A_EN, 32'h1);
    clear <= 1'b1;
    repeat (20) @(posedge pclk);
    clear <= 1'b0;
    cmp("waiting on gate", 33'h0, {32'h0, sequence_active});
    gate_req <= 1'b1;
    wait_act(1'b1, 40);
    wait_act(1'b0, 2000);
    cmp("gated pulses", 33'h2, {1'b0, pulses});
    cmp("gated high cycles", {1'b0, 32'(2 * TK)}, {1'b0, high_len});
    summarize();
  end
endmodule // pulse_train_control_interface_tb
